//--- rtl/pbsp_burst_ctr.sv
// burst address low bits from the loaded start bits and the burst position
// assumes the caller keeps the start bits and the position in its own flops
`timescale 1ns/1ns

module pbsp_burst_ctr
    import pbsp_pkg::*;
(
    input  wire logic [1:0] start_low,
    input  wire logic [1:0] position,
    input  wire logic       burst_order_sel,
    output logic      [1:0] addr_low
);

    // linear wraps inside the four-word block, interleaved flips bits
    assign addr_low = burst_order_sel ? (start_low ^ position)      // R7
                                      : 2'(start_low + position);   // R8

endmodule : pbsp_burst_ctr

//--- rtl/pbsp_pkg.sv
// constants, states and pin bundle of the pipelined burst static memory port
// assumes one clock (pclk, 100 MHz) and an apb master for the small control file
//
// How it works
// R1 - store 1,048,576 words of 32 or 36 bits on one shared data bus
// R2 - read data goes out one edge after its address is registered
// R3 - processor strobe low with all enables starts a read, loading the address
// R4 - bus master holds output enable low to see read data
// R5 - burst advance ignored on processor strobe edge, sampled on later edges
// R6 - burst address steps only with both strobes high and advance low
// R7 - burst order select high or floating gives interleaved sequence
// R8 - burst order select low gives linear sequence
// R9 - bus master turns outputs off, then asserts a write command
// R10 - global write low writes every bit whatever the byte lanes say
// R11 - with global write high, only enabled lanes under master byte write
// R12 - byte lane writes ignored on processor strobe edge, sampled afterwards
// R13 - any byte lane sampled low turns data drivers off, ignoring output enable
// R14 - byte lane sampled low captures the data bus for writing
// R15 - write burst steps when byte lane and advance are both sampled low
// R16 - single-cycle deselect: drivers off one clock after deselect
// R17 - bus master keeps processor strobe high when using controller strobe
// R18 - controller strobe cycles sample the write enables on the start edge
// R19 - three chip enables must all be active with a strobe to start; the controller strobe starts with only the two secondary enables
// R20 - inactive master enable blocks processor strobe, not controller strobe
// R21 - first secondary enable is active high, second active low
// R22 - master byte write low, global high: any lane means write, none read
// R23 - snooze ignores all inputs, floats outputs and keeps stored data
// R24 - bus master gives only reads or deselects while leaving snooze

package pbsp_pkg;

    // memory geometry
    localparam int unsigned PBSP_ADDR_W  = 20;
    localparam int unsigned PBSP_DEPTH   = 1048576;
    localparam int unsigned PBSP_LANES   = 4;
    localparam int unsigned PBSP_LANE_W  = 8;
    localparam int unsigned PBSP_WORD_W  = 36;
    localparam int unsigned PBSP_PAR_LSB = 32;    // lane n parity bit sits at 32+n

    // apb register file
    localparam logic [11:0] PBSP_REG_CTRL   = 12'h000;
    localparam logic [11:0] PBSP_REG_STATUS = 12'h004;
    localparam int unsigned PBSP_CTRL_WIDE_BIT = 0;     // 1: 36-bit words, 0: 32-bit
    localparam logic        PBSP_CTRL_WIDE_RST = 1'b1;
    localparam int unsigned PBSP_STAT_SNOOZE_BIT = 0;
    localparam int unsigned PBSP_STAT_READ_BIT   = 1;
    localparam int unsigned PBSP_STAT_WRITE_BIT  = 2;
    localparam int unsigned PBSP_STAT_ADDR_LSB   = 4;

    // burst position after a new address is loaded
    localparam logic [1:0] PBSP_CNT_RST = 2'h0;

    // cycle state, gray along idle -> read -> write
    typedef enum logic [1:0]
    {
        PBSP_IDLE  = 2'b00,
        PBSP_READ  = 2'b01,
        PBSP_WRITE = 2'b11
    } pbsp_state_t;

    // synchronous control pins of the memory port, all active low unless named
    typedef struct packed {
        logic                   proc_addr_strobe_n;
        logic                   ctrl_addr_strobe_n;
        logic                   burst_advance_n;
        logic                   global_write_n;
        logic                   byte_write_master_n;
        logic [PBSP_LANES-1:0]  byte_lane_writes_n;
        logic                   master_select_n;
        logic                   select_high;
        logic                   select_low_n;
        logic                   out_enable_n;
        logic                   burst_order_sel;
        logic                   snooze_req;
        logic [PBSP_ADDR_W-1:0] addr;
    } pbsp_pins_t;

endpackage : pbsp_pkg

//--- rtl/pbsp_port.sv
// pipelined burst static memory port: strobes, burst counter, read pipeline,
// byte-lane writes, single-cycle deselect, snooze, plus a two-register apb file
// assumes every memory pin is synchronous to pclk, including output enable and
// snooze, which are therefore seen one edge late on the data drivers
`timescale 1ns/1ns

module pbsp_port
    import pbsp_pkg::*;
(
    input  wire logic                            pclk,
    input  wire logic                            presetn,
    input  wire logic [11:0]                     paddr,
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [31:0]                     pwdata,
    output logic      [31:0]                     prdata,
    output logic                                 pready,
    output logic                                 pslverr,
    input  wire pbsp_pkg::pbsp_pins_t            pins,
    input  wire logic [pbsp_pkg::PBSP_WORD_W-1:0] dq_i,
    output logic      [pbsp_pkg::PBSP_WORD_W-1:0] dq_o,
    output logic                                 dq_oe_n
);

    import pbsp_pkg::*;

    // storage, no reset: contents survive reset and snooze alike
    logic [PBSP_WORD_W-1:0] mem [PBSP_DEPTH];

    // cycle control
    pbsp_state_t            state;
    pbsp_state_t            next_state;
    logic [PBSP_ADDR_W-1:0] base_addr;
    logic [1:0]             position;
    logic [1:0]             next_position;
    logic                   rd_pend;
    logic [PBSP_ADDR_W-1:0] rd_addr;
    logic                   ctrl_wide;
    logic                   snoozed;

    // strobe and enable qualification
    wire snooze     = pins.snooze_req;
    wire sec_ok     = pins.select_high & ~pins.select_low_n;                   // R21
    wire proc_seen  = ~pins.proc_addr_strobe_n & ~pins.master_select_n;        // R20
    wire ctrl_seen  = ~pins.ctrl_addr_strobe_n;                                // R20
    wire proc_start = ~snooze & proc_seen & sec_ok;                            // R3 R19
    wire ctrl_start = ~snooze & ~proc_seen & ctrl_seen & sec_ok;               // R19
    wire any_start  = proc_start | ctrl_start;
    wire deselect   = ~snooze & (proc_seen | ctrl_seen) & ~sec_ok;
    wire strobes_hi = pins.proc_addr_strobe_n & pins.ctrl_addr_strobe_n;
    wire cont       = ~snooze & strobes_hi & (state != PBSP_IDLE);

    // write decision; lanes are not looked at on a processor strobe edge
    logic [PBSP_LANES-1:0] lane_mask;
    wire any_wr     = |lane_mask;
    wire wr_start   = ctrl_start & any_wr;                                     // R18
    wire wr_cont    = cont & any_wr;                                           // R12 R14
    wire do_write   = wr_start | wr_cont;
    wire do_read    = proc_start | (ctrl_start & ~any_wr) | (cont & ~any_wr); // R3
    wire lane_low   = ~(&pins.byte_lane_writes_n) & pins.proc_addr_strobe_n
                      & ~snooze;                                               // R12

    // advance ignored on start edges since cont needs both strobes high
    wire advance    = cont & ~pins.burst_advance_n;                            // R5 R6 R15

    pbsp_write_decode u_wdec
    (
        .global_write_n      (pins.global_write_n),
        .byte_write_master_n (pins.byte_write_master_n),
        .byte_lane_writes_n  (pins.byte_lane_writes_n),
        .lane_mask           (lane_mask)
    );

    // burst position used by this edge's access
    assign next_position = advance ? 2'(position + 2'h1) : position;

    logic [1:0] burst_low;

    pbsp_burst_ctr u_bctr
    (
        .start_low       (base_addr[1:0]),
        .position        (next_position),
        .burst_order_sel (pins.burst_order_sel),
        .addr_low        (burst_low)
    );

    // a start uses the bus address as is; a burst edge uses the counter
    wire [PBSP_ADDR_W-1:0] burst_addr = {base_addr[PBSP_ADDR_W-1:2], burst_low};
    wire [PBSP_ADDR_W-1:0] op_addr    = any_start ? pins.addr : burst_addr;

    // next cycle state
    always_comb
    begin
        next_state = state;
        case (state)
            PBSP_IDLE, PBSP_READ, PBSP_WRITE:
            begin
                if (snooze || deselect)
                    next_state = PBSP_IDLE;                                    // R23
                else if (do_write)
                    next_state = PBSP_WRITE;
                else if (do_read)
                    next_state = PBSP_READ;
            end
            default:
                next_state = PBSP_IDLE;
        endcase
    end

    // state and burst registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state     <= PBSP_IDLE;
            base_addr <= '0;
            position  <= PBSP_CNT_RST;
        end
        else
        begin
            state <= next_state;
            if (any_start)
            begin
                base_addr <= pins.addr;                                        // R3
                position  <= PBSP_CNT_RST;
            end
            else if (cont)
                position <= next_position;                                     // R6
        end
    end

    // merged write word: masked lanes take the bus, others keep old contents
    logic [PBSP_WORD_W-1:0] old_word;
    logic [PBSP_WORD_W-1:0] new_word;
    assign old_word = mem[op_addr];

    genvar ln;
    generate
        for (ln = 0; ln < PBSP_LANES; ln++)
        begin : g_lane
            localparam int unsigned LO = ln * PBSP_LANE_W;
            localparam int unsigned PB = PBSP_PAR_LSB + ln;
            // narrow words write zero into the parity bit of each written lane
            assign new_word[LO +: PBSP_LANE_W] = lane_mask[ln] ? dq_i[LO +: PBSP_LANE_W]
                                                               : old_word[LO +: PBSP_LANE_W];
            assign new_word[PB] = lane_mask[ln] ? (dq_i[PB] & ctrl_wide)
                                                : old_word[PB];               // R1
        end
    endgenerate

    // data input capture straight into the array on the sampling edge
    always_ff @(posedge pclk)
    begin
        if (do_write)
            mem[op_addr] <= new_word;                                          // R10 R11 R14
    end

    // first pipeline stage: registered read address
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rd_pend <= 1'b0;
            rd_addr <= '0;
        end
        else
        begin
            rd_pend <= do_read;                                                // R16
            if (do_read)
                rd_addr <= op_addr;                                            // R2
        end
    end

    // second pipeline stage: output register and driver enable (low = drive)
    wire [PBSP_WORD_W-1:0] rd_word  = mem[rd_addr];
    wire [PBSP_WORD_W-1:0] rd_shown = ctrl_wide ? rd_word
                                    : {4'h0, rd_word[PBSP_PAR_LSB-1:0]};
    wire drive = rd_pend & ~pins.out_enable_n & ~lane_low & ~snooze;          // R13 R23

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dq_o    <= '0;
            dq_oe_n <= 1'b1;
        end
        else
        begin
            if (rd_pend)
                dq_o <= rd_shown;                                              // R2
            dq_oe_n <= ~drive;                                                 // R16
        end
    end

    // snooze flag for status, sampled like every other pin
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            snoozed <= 1'b0;
        else
            snoozed <= snooze;
    end

    // apb decode; one wait state keeps every apb output on a flop
    wire apb_access = psel & penable;
    wire apb_done   = apb_access & pready;
    wire hit_ctrl   = (paddr == PBSP_REG_CTRL);
    wire hit_status = (paddr == PBSP_REG_STATUS);
    wire apb_miss   = ~(hit_ctrl | hit_status);

    logic [31:0] ctrl_value;
    logic [31:0] status_value;
    always_comb
    begin
        ctrl_value = 32'h0000_0000;
        ctrl_value[PBSP_CTRL_WIDE_BIT] = ctrl_wide;
        status_value = 32'h0000_0000;
        status_value[PBSP_STAT_SNOOZE_BIT] = snoozed;
        status_value[PBSP_STAT_READ_BIT]   = (state == PBSP_READ);
        status_value[PBSP_STAT_WRITE_BIT]  = (state == PBSP_WRITE);
        status_value[PBSP_STAT_ADDR_LSB +: PBSP_ADDR_W] = base_addr;
    end

    wire [31:0] read_mux = hit_ctrl   ? ctrl_value
                         : hit_status ? status_value
                         : 32'h0000_0000;

    // apb answer: ready rises on the second access cycle, error on a miss
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= apb_access & ~pready;
            pslverr <= apb_access & ~pready & apb_miss;
            if (apb_access && !pready && !pwrite)
                prdata <= read_mux;
        end
    end

    // control register: word width; writes land on the ready edge only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_wide <= PBSP_CTRL_WIDE_RST;
        else if (apb_done && pwrite && hit_ctrl)
            ctrl_wide <= pwdata[PBSP_CTRL_WIDE_BIT];
    end

endmodule : pbsp_port

//--- rtl/pbsp_write_decode.sv
// per-lane write mask from the global, master and lane write pins
// assumes the pins are already sampled on the current edge
`timescale 1ns/1ns

module pbsp_write_decode
    import pbsp_pkg::*;
(
    input  wire logic                  global_write_n,
    input  wire logic                  byte_write_master_n,
    input  wire logic [PBSP_LANES-1:0] byte_lane_writes_n,
    output logic      [PBSP_LANES-1:0] lane_mask
);

    // global write overrides lanes; lanes count only under master byte write
    assign lane_mask = !global_write_n     ? {PBSP_LANES{1'b1}}      // R10
                     : !byte_write_master_n ? ~byte_lane_writes_n    // R11 R22
                     : {PBSP_LANES{1'b0}};

endmodule : pbsp_write_decode

//--- tb/pbsp_bus_model.sv
// bus master data drivers and the shared data wire seen by the port
// assumes the bench says when the master drives; the wire has no pull
`timescale 1ns/1ns

module pbsp_bus_model
    import pbsp_pkg::*;
(
    input  wire logic                             pclk,
    input  wire logic                             m_drive,
    input  wire logic [pbsp_pkg::PBSP_WORD_W-1:0] m_data,
    input  wire logic [pbsp_pkg::PBSP_WORD_W-1:0] dq_o,
    input  wire logic                             dq_oe_n,
    output logic      [pbsp_pkg::PBSP_WORD_W-1:0] dq_i
);
    import pbsp_pkg::*;
    logic [PBSP_WORD_W-1:0] last;
    // keep the last level so a floating wire shows its inverse, not a guess
    always_ff @(posedge pclk)
    begin
        last <= dq_i;
    end
    // both driving is contention and shows unknown
    always_comb
    begin
        if (m_drive && !dq_oe_n)
            dq_i = 'x;
        else if (m_drive)
            dq_i = m_data;
        else if (!dq_oe_n)
            dq_i = dq_o;
        else
            dq_i = ~last;
    end
endmodule : pbsp_bus_model

//--- tb/pbsp_port_assertions.sv
// checker for the memory port pins and the apb handshake of pbsp_port
// assumes every pin is sampled on rising pclk, presetn async active low
`timescale 1ns/1ns

module pbsp_port_assertions
    import pbsp_pkg::*;
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pready,
    input  wire logic                 pslverr,
    input  wire pbsp_pkg::pbsp_pins_t pins,
    input  wire logic                 dq_oe_n
);
    import pbsp_pkg::*;
    // qualified start, burst continue and deselect decodes
    wire sel_ok  = pins.select_high && !pins.select_low_n;
    wire start_p = !pins.proc_addr_strobe_n && !pins.master_select_n && sel_ok
                   && !pins.snooze_req;
    wire go_on   = pins.proc_addr_strobe_n && pins.ctrl_addr_strobe_n
                   && !pins.out_enable_n && &pins.byte_lane_writes_n && !pins.snooze_req;
    wire desel   = (!pins.ctrl_addr_strobe_n
                   || !pins.proc_addr_strobe_n && !pins.master_select_n) && !sel_ok;
    wire oe_ok   = !pins.out_enable_n && !pins.snooze_req;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_RD_PIPE: assert property (start_p ##1 go_on |=> !dq_oe_n)
        else $error("read data not driven one edge after the address");
    AST_SNOOZE: assert property (pins.snooze_req |=> dq_oe_n)
        else $error("drivers on after snooze sampled");
    AST_LANE_OFF: assert property (pins.proc_addr_strobe_n && !(&pins.byte_lane_writes_n)
        |=> dq_oe_n)
        else $error("drivers on after a lane write sampled");
    AST_DESEL: assert property (desel |-> ##2 dq_oe_n)
        else $error("drivers still on one clock after deselect");
    AST_BLOCK: assert property (!pins.proc_addr_strobe_n && pins.master_select_n
        && pins.ctrl_addr_strobe_n |-> ##2 dq_oe_n)
        else $error("processor strobe not blocked by master select");
    AST_OE_CAUSE: assert property (!dq_oe_n |-> $past(oe_ok))
        else $error("drivers on without output enable");
    AST_APB_WAIT: assert property ($rose(penable) && psel |-> !pready ##1 pready)
        else $error("apb ready not on second access cycle");
    AST_ERR_RDY: assert property (pslverr |-> pready)
        else $error("apb error without ready");
    AST_RDY_PULSE: assert property (pready |=> !pready)
        else $error("apb ready longer than one cycle");
endmodule : pbsp_port_assertions

bind pbsp_port pbsp_port_assertions u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .pins(pins), .dq_oe_n(dq_oe_n)
);

//--- tb/pbsp_port_tb.sv
// self-checking bench: writes, bursts, byte lanes, deselect, snooze, apb file
// assumes rtl/pbsp_pkg.sv is compiled first
`timescale 1ns/1ns

module pbsp_port_tb;
    import pbsp_pkg::*;
    // strobe sets {proc, ctrl, adv, global, master, snooze}
    localparam logic [5:0]  S_IDLE = 6'h3E;
    localparam logic [5:0]  S_PRD  = 6'h1E;
    localparam logic [5:0]  S_ADV  = 6'h36;
    localparam logic [5:0]  S_CRD  = 6'h2E;
    localparam logic [5:0]  S_CGW  = 6'h2A;
    localparam logic [5:0]  S_CBW  = 6'h2C;
    localparam logic [5:0]  S_SNZ  = 6'h2B;
    localparam logic [5:0]  S_SNR  = 6'h1F;
    localparam logic [5:0]  S_PMB  = 6'h1C;
    localparam logic [5:0]  S_WBA  = 6'h34;
    localparam logic [19:0] BASE   = 20'h5A3C0;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        dq_oe_n;
    logic        m_drive = 1'b0;
    pbsp_pins_t  pins;
    logic [35:0] dq_i;
    logic [35:0] dq_o;
    logic [35:0] m_data = 36'h0;
    logic [35:0] mdl [4];
    int          err_total = 0;
    int          checks = 0;
    int          cyc_cnt = 0;

    pbsp_port dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pins(pins), .dq_i(dq_i), .dq_o(dq_o),
        .dq_oe_n(dq_oe_n));
    pbsp_bus_model u_bus (.pclk(pclk), .m_drive(m_drive), .m_data(m_data),
        .dq_o(dq_o), .dq_oe_n(dq_oe_n), .dq_i(dq_i));

    // 100 MHz clock
    always #5 pclk = ~pclk;

    task automatic test_done();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : test_done

    // watchdog: the run needs about a hundred cycles
    always @(posedge pclk)
    begin
        cyc_cnt++;
        if (cyc_cnt == 3000)
        begin
            err_total++;
            test_done();
        end
    end

    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one memory bus cycle; the master drives data and drops enable on writes
    task automatic drv(input logic [5:0] st, input logic [3:0] ln,
                       input logic [19:0] a, input logic [35:0] d);
        @(posedge pclk);
        {pins.proc_addr_strobe_n, pins.ctrl_addr_strobe_n, pins.burst_advance_n,
         pins.global_write_n, pins.byte_write_master_n, pins.snooze_req} <= st;
        pins.byte_lane_writes_n <= ln;
        pins.addr <= a;
        m_data <= d;
        m_drive <= !st[2] || !(&ln);
        pins.out_enable_n <= !st[2] || !(&ln);
    endtask : drv

    // apb transfer held until pready, judged at that edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] exp, input logic exp_err);
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        chk(36'(pslverr), 36'(exp_err));
        if (!wr)
            chk(36'(prdata), 36'(exp));
    endtask : apb

    task automatic rd1(input logic [19:0] a, input logic [35:0] exp);
        drv(S_PRD, 4'hF, a, 36'h0);
        drv(S_IDLE, 4'hF, a, 36'h0);
        drv(S_IDLE, 4'hF, a, 36'h0);
        #1 chk(dq_o, exp);
    endtask : rd1

    // width bit moves both ways; a missed write must not reach it
    task automatic t_regs();
        apb(1'b0, PBSP_REG_CTRL, 32'h0, 32'h1, 1'b0);
        apb(1'b1, PBSP_REG_CTRL, 32'h0, 32'h0, 1'b0);
        apb(1'b0, PBSP_REG_CTRL, 32'h0, 32'h0, 1'b0);
        apb(1'b0, 12'h010, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 12'h010, 32'h5, 32'h0, 1'b1);
        apb(1'b0, PBSP_REG_CTRL, 32'h0, 32'h0, 1'b0);
        apb(1'b1, PBSP_REG_CTRL, 32'h1, 32'h0, 1'b0);
        apb(1'b0, PBSP_REG_CTRL, 32'h0, 32'h1, 1'b0);
    endtask : t_regs

    // controller strobe writes; the first with master select off
    task automatic t_write();
        for (int j = 0; j < 4; j++)
        begin
            mdl[j] = 36'h9_1234_5670 + 36'(j * 17);
            drv(S_CGW, 4'h0, BASE | 20'(j), mdl[j]);
            pins.master_select_n <= (j == 0);
        end
        drv(S_IDLE, 4'hF, BASE, 36'h0);
        apb(1'b0, PBSP_REG_STATUS, 32'h0, {8'h00, BASE | 20'h3, 4'h2}, 1'b0);
    endtask : t_write

    task automatic t_burst(input logic order);
        logic [1:0] ix;
        drv(S_PRD, 4'hF, BASE | 20'h1, 36'h0);
        pins.burst_order_sel <= order;
        drv(S_ADV, 4'hF, BASE, 36'h0);
        for (int i = 0; i < 4; i++)
        begin
            ix = order ? (2'h1 ^ 2'(i)) : (2'h1 + 2'(i));
            drv((i < 2) ? S_ADV : S_IDLE, 4'hF, BASE, 36'h0);
            #1 chk(dq_o, mdl[ix]);
            chk(36'(dq_oe_n), 36'h0);
        end
    endtask : t_burst

    task automatic t_desel();
        drv(S_CRD, 4'hF, BASE, 36'h0);
        pins.select_high <= 1'b0;
        drv(S_IDLE, 4'hF, BASE, 36'h0);
        pins.select_high <= 1'b1;
        #1 chk(36'(dq_oe_n), 36'h0);
        drv(S_IDLE, 4'hF, BASE, 36'h0);
        #1 chk(36'(dq_oe_n), 36'h1);
    endtask : t_desel

    task automatic t_block();
        drv(S_PRD, 4'hF, BASE | 20'h1, 36'h0);
        pins.master_select_n <= 1'b1;
        drv(S_IDLE, 4'hF, BASE, 36'h0);
        pins.master_select_n <= 1'b0;
        drv(S_IDLE, 4'hF, BASE, 36'h0);
        #1 chk(36'(dq_oe_n), 36'h1);
    endtask : t_block

    // lanes 0 and 2 written, master-only cycle reads, proc edge ignores lanes
    task automatic t_bytes();
        drv(S_CBW, 4'hA, BASE | 20'h2, 36'hF_FFFF_FFFF);
        mdl[2] = mdl[2] | 36'h5_00FF_00FF;
        drv(S_CBW, 4'hF, BASE | 20'h3, 36'h0);
        drv(S_PMB, 4'h0, BASE, 36'h0);
        drv(S_IDLE, 4'hF, BASE, 36'h0);
        drv(S_IDLE, 4'hF, BASE, 36'h0);
        #1 chk(dq_o, mdl[0]);
        rd1(BASE | 20'h2, mdl[2]);
        rd1(BASE | 20'h3, mdl[3]);
    endtask : t_bytes

    // write burst step: lanes and advance sampled low on a continue edge
    task automatic t_wburst();
        t_desel();
        mdl[1] = 36'hA_5A5A_0F0F;
        drv(S_CRD, 4'hF, BASE, 36'h0);
        drv(S_WBA, 4'h0, BASE, mdl[1]);
        drv(S_IDLE, 4'hF, BASE, 36'h0);
        rd1(BASE | 20'h1, mdl[1]);
    endtask : t_wburst

    // snoozed write and snoozed read are both ignored
    task automatic t_snooze();
        t_desel();
        drv(S_SNZ, 4'h0, BASE | 20'h1, 36'h0);
        drv(S_SNR, 4'hF, BASE | 20'h1, 36'h0);
        drv(S_IDLE, 4'hF, BASE, 36'h0);
        drv(S_IDLE, 4'hF, BASE, 36'h0);
        #1 chk(36'(dq_oe_n), 36'h1);
        rd1(BASE | 20'h1, mdl[1]);
    endtask : t_snooze

    // reset for eight cycles, then the scenarios in order
    initial
    begin
        pins = {5'h1F, 4'hF, 3'b010, 1'b0, 1'b1, 1'b0, 20'h0};
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_write();
        t_burst(1'b1);
        t_desel();
        t_burst(1'b0);
        t_desel();
        t_block();
        t_bytes();
        t_wburst();
        t_snooze();
        test_done();
    end
endmodule : pbsp_port_tb
